// ### pkg/mbo_pkg.sv
package mbo_pkg;
    // operation codes presented by the pipeline
    typedef enum logic [2:0] {
        MBO_OP_NONE,
        MBO_OP_ACCESS,
        MBO_OP_ORDER,
        MBO_OP_COMPLETE,
        MBO_OP_FLUSH
    } mbo_op_t;

    localparam int MBO_ADDR_W = 32;
    localparam int MBO_DATA_W = 32;
    localparam int MBO_WORDS_W = 4;
    localparam int MBO_OUT_W = 4;
    localparam logic [MBO_ADDR_W-1:0] MBO_WORD_STEP = 32'h0000_0004;
    localparam logic [MBO_WORDS_W-1:0] MBO_ONE_WORD = 4'h1;
    localparam logic [MBO_OUT_W-1:0] MBO_OUT_ONE = 4'h1;
    localparam logic [MBO_OUT_W-1:0] MBO_OUT_ZERO = 4'h0;

    // one instruction handed over by the pipeline
    typedef struct packed {
        mbo_op_t op;
        logic write;
        logic [MBO_ADDR_W-1:0] base;
        logic [MBO_WORDS_W-1:0] words;
        logic descending;
        logic free_order;
        logic ctx_alter;
        logic [MBO_DATA_W-1:0] wdata;
    } mbo_req_t;

    // one word access toward the memory system
    typedef struct packed {
        logic valid;
        logic write;
        logic [MBO_ADDR_W-1:0] addr;
        logic [MBO_DATA_W-1:0] wdata;
        logic ctx_alter;
    } mbo_mem_t;
endpackage

// ### logic/mbo_unit.sv
`timescale 1ns/1ps
// Overview of operation
// - each word of a multi-word transfer is issued as its own access.
// - accesses of different instructions issue strictly in program order.
// - block transfers without program counter go lowest address first.
// - block load including program counter may use any order.
// - doubleword load or store words may issue in either order.
// - data barriers touch only explicit accesses, never instruction fetch.
// - every barrier is system-wide whatever its domain or type argument.
// - accesses before a data order barrier are seen before later ones.
// - same peripheral sees earlier accesses before later ones across barrier.
// - data order barrier does not stall non-memory instructions.
// - completion barrier gives all the guarantees of the order barrier.
// - completion barrier waits until all earlier accesses are complete.
// - completion barrier waits for context-altering control space writes.
// - instructions after completion barrier held until barrier completes.
// - flush barrier flushes pipeline; later instructions refetched afterwards.
// - branches after flush barrier predicted with the new context.
// - context changes after flush barrier wait until it has executed.
// - prefetch depth and predicted path are free implementation choices.
// - stale prefetched copies may execute unless a flush barrier intervenes.
// - control space context writes take effect when the access completes; the code applies them on the ack that leaves nothing outstanding or queued.
module mbo_unit
    import mbo_pkg::*;
#(
    parameter int OUT_MAX = 8
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire mbo_req_t req_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    output mbo_mem_t mem_out,
    input wire logic mem_ready_in,
    input wire logic mem_ack_in,
    output logic exec_hold_out,
    output logic flush_out,
    output logic ctx_apply_out,
    output logic predict_ctx_new_out,
    output logic idle_out
);
    typedef enum logic [1:0] {
        MBO_IDLE,
        MBO_ISSUE,
        MBO_DRAIN,
        MBO_FLUSHING
    } mbo_state_t;

    typedef struct packed {
        mbo_state_t state;
        mbo_req_t cur;
        logic [MBO_WORDS_W-1:0] left;
        logic [MBO_ADDR_W-1:0] addr;
        logic [MBO_OUT_W-1:0] outstanding;
        logic ctx_pending;
        logic drain_full;
        logic req_ready;
        mbo_mem_t mem;
        logic exec_hold;
        logic flush;
        logic ctx_apply;
        logic predict_new;
        logic idle;
    } mbo_regs_t;

    mbo_regs_t r;
    mbo_regs_t next_r;
    logic issue_fire;
    logic take;

    assign issue_fire = r.mem.valid && mem_ready_in;
    assign take = r.req_ready && req_valid_in;

    // one combinational image of all state
    always_comb begin
        next_r = r;
        next_r.flush = 1'b0;
        next_r.ctx_apply = 1'b0;
        // prediction context flag follows the flush pulse by one cycle
        next_r.predict_new = r.flush;
        // outstanding counts accepted but unacknowledged accesses
        case ({issue_fire, mem_ack_in && (r.outstanding != MBO_OUT_ZERO)})
            2'b10: next_r.outstanding = r.outstanding + MBO_OUT_ONE;
            2'b01: next_r.outstanding = r.outstanding - MBO_OUT_ONE;
            default: next_r.outstanding = r.outstanding;
        endcase
        if (issue_fire) begin
            next_r.mem.valid = 1'b0;
        end
        // context write takes effect on the ack that leaves nothing outstanding or queued; acks return in
        // order, so that ack is the context word's own only if no later word was issued behind it
        if (mem_ack_in && r.ctx_pending && r.outstanding == MBO_OUT_ONE && !r.mem.valid &&
            !(r.state == MBO_ISSUE && r.left != '0)) begin
            next_r.ctx_apply = 1'b1;
            next_r.ctx_pending = 1'b0;
        end
        case (r.state)
            MBO_IDLE: begin
                if (take) begin
                    next_r.cur = req_in;
                    next_r.req_ready = 1'b0;
                    next_r.idle = 1'b0;
                    // barriers ignore domain/type arguments: always full system
                    case (req_in.op)
                        MBO_OP_ACCESS: begin
                            next_r.state = MBO_ISSUE;
                            next_r.left = req_in.words;
                            // lowest word first; descending lists start at bottom
                            next_r.addr = req_in.descending ?
                                req_in.base - MBO_WORD_STEP *
                                MBO_ADDR_W'(req_in.words) : req_in.base;
                        end
                        MBO_OP_ORDER: begin
                            // only memory issue waits; other instructions run
                            next_r.state = MBO_DRAIN;
                            next_r.drain_full = 1'b0;
                        end
                        MBO_OP_COMPLETE: begin
                            next_r.state = MBO_DRAIN;
                            next_r.drain_full = 1'b1;
                            next_r.exec_hold = 1'b1;
                        end
                        MBO_OP_FLUSH: begin
                            next_r.state = MBO_FLUSHING;
                            next_r.exec_hold = 1'b1;
                        end
                        default: begin
                            next_r.req_ready = 1'b1;
                            next_r.idle = 1'b1;
                        end
                    endcase
                end
            end
            MBO_ISSUE: begin
                // a new word is offered only once the previous one was taken
                // and only while the outstanding count leaves room for it
                if (!r.mem.valid || issue_fire) begin
                    if (r.left == '0) begin
                        // ascending order also serves the free-order cases
                        next_r.state = MBO_IDLE;
                        next_r.req_ready = 1'b1;
                    end else if (next_r.outstanding < MBO_OUT_W'(OUT_MAX)) begin
                        next_r.mem.valid = 1'b1;
                        next_r.mem.write = r.cur.write;
                        next_r.mem.wdata = r.cur.wdata;
                        next_r.mem.ctx_alter = r.cur.ctx_alter && r.cur.write;
                        next_r.mem.addr = r.addr;
                        next_r.addr = r.addr + MBO_WORD_STEP;
                        next_r.left = r.left - MBO_ONE_WORD;
                        if (r.cur.ctx_alter && r.cur.write) begin
                            next_r.ctx_pending = 1'b1;
                        end
                    end
                end
            end
            MBO_DRAIN: begin
                // instruction fetch is not counted here, only data accesses
                if (next_r.outstanding == MBO_OUT_ZERO && !r.mem.valid &&
                    !next_r.ctx_pending) begin
                    next_r.state = MBO_IDLE;
                    next_r.req_ready = 1'b1;
                    next_r.exec_hold = 1'b0;
                    next_r.idle = 1'b1;
                end
            end
            MBO_FLUSHING: begin
                // flush after earlier context is applied; prefetch policy free
                if (!r.ctx_pending) begin
                    next_r.flush = 1'b1;
                    next_r.exec_hold = 1'b0;
                    next_r.state = MBO_IDLE;
                    next_r.req_ready = 1'b1;
                    next_r.idle = 1'b1;
                end
            end
            default: next_r.state = MBO_IDLE;
        endcase
        if (r.state == MBO_ISSUE && next_r.state == MBO_IDLE) begin
            next_r.idle = (next_r.outstanding == MBO_OUT_ZERO);
        end else if (r.state == MBO_IDLE && !take) begin
            next_r.idle = (next_r.outstanding == MBO_OUT_ZERO);
        end
    end

    // state register: the whole struct moves in one step
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r <= '0;
            r.req_ready <= 1'b1;
            r.idle <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign req_ready_out = r.req_ready;
    assign mem_out = r.mem;
    assign exec_hold_out = r.exec_hold;
    assign flush_out = r.flush;
    assign ctx_apply_out = r.ctx_apply;
    assign predict_ctx_new_out = r.predict_new;
    assign idle_out = r.idle;

    property p_complete_hold;
        @(posedge clock_in) disable iff (!nrst_in)
        (take && req_in.op == MBO_OP_COMPLETE) |=> exec_hold_out;
    endproperty
    a_complete_hold: assert property (p_complete_hold) else $error("hold missing");

    property p_drain_done;
        @(posedge clock_in) disable iff (!nrst_in)
        (r.state == MBO_DRAIN && $past(r.state) == MBO_DRAIN) |-> !r.mem.valid;
    endproperty
    a_drain_done: assert property (p_drain_done) else $error("issue in drain");

    property p_release_empty;
        @(posedge clock_in) disable iff (!nrst_in)
        ($past(r.state) == MBO_DRAIN && r.state == MBO_IDLE) |-> r.outstanding == '0;
    endproperty
    a_release_empty: assert property (p_release_empty) else $error("early release");

    property p_ascending;
        @(posedge clock_in) disable iff (!nrst_in)
        (issue_fire && r.left != '0 && r.state == MBO_ISSUE) |=>
            (mem_out.valid |-> mem_out.addr == $past(mem_out.addr) + MBO_WORD_STEP);
    endproperty
    a_ascending: assert property (p_ascending) else $error("word order");

    property p_flush_pulse;
        @(posedge clock_in) disable iff (!nrst_in)
        flush_out |=> !flush_out ##0 predict_ctx_new_out;
    endproperty
    a_flush_pulse: assert property (p_flush_pulse) else $error("flush shape");

    property p_flush_ctx;
        @(posedge clock_in) disable iff (!nrst_in)
        flush_out |-> !r.ctx_pending;
    endproperty
    a_flush_ctx: assert property (p_flush_ctx) else $error("flush before ctx");

    property p_order_nohold;
        @(posedge clock_in) disable iff (!nrst_in)
        (take && req_in.op == MBO_OP_ORDER && !exec_hold_out) |=> !exec_hold_out;
    endproperty
    a_order_nohold: assert property (p_order_nohold) else $error("order stalls");

    property p_single_word;
        @(posedge clock_in) disable iff (!nrst_in)
        (r.state == MBO_ISSUE && mem_out.valid && !mem_ready_in) |=>
            $stable(mem_out.addr);
    endproperty
    a_single_word: assert property (p_single_word) else $error("word dropped");

    // issue bound, serialisation and idle/ready checks
    property p_out_cap;
        @(posedge clock_in) disable iff (!nrst_in)
        r.outstanding <= MBO_OUT_W'(OUT_MAX);
    endproperty
    a_out_cap: assert property (p_out_cap) else $error("outstanding over cap");

    property p_rose_issue;
        @(posedge clock_in) disable iff (!nrst_in)
        $rose(mem_out.valid) |-> r.state == MBO_ISSUE;
    endproperty
    a_rose_issue: assert property (p_rose_issue) else $error("word outside issue");

    property p_idle_ready;
        @(posedge clock_in) disable iff (!nrst_in)
        idle_out |-> req_ready_out;
    endproperty
    a_idle_ready: assert property (p_idle_ready) else $error("idle but not ready");

    // barrier hold and context checks
    property p_hold_drain;
        @(posedge clock_in) disable iff (!nrst_in)
        (r.state == MBO_DRAIN && r.cur.op == MBO_OP_COMPLETE) |-> exec_hold_out;
    endproperty
    a_hold_drain: assert property (p_hold_drain) else $error("hold dropped early");

    property p_flush_hold;
        @(posedge clock_in) disable iff (!nrst_in)
        (r.state == MBO_FLUSHING) |-> exec_hold_out;
    endproperty
    a_flush_hold: assert property (p_flush_hold) else $error("flush without hold");

    property p_idle_free;
        @(posedge clock_in) disable iff (!nrst_in)
        (r.state == MBO_IDLE) |-> !exec_hold_out;
    endproperty
    a_idle_free: assert property (p_idle_free) else $error("hold left in idle");

    property p_ctx_src;
        @(posedge clock_in) disable iff (!nrst_in)
        ctx_apply_out |-> $past(r.ctx_pending);
    endproperty
    a_ctx_src: assert property (p_ctx_src) else $error("context without write");

    property p_predict_src;
        @(posedge clock_in) disable iff (!nrst_in)
        predict_ctx_new_out |-> $past(flush_out);
    endproperty
    a_predict_src: assert property (p_predict_src) else $error("predict without flush");
endmodule

// ### sim/mbo_mem_model.sv
`timescale 1ns/1ps
// far-side memory: takes words, acknowledges each one later, may stall
module mbo_mem_model
    import mbo_pkg::*;
(
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire mbo_mem_t mem_in,
    input wire logic slow_in,
    input wire logic ack_stop_in,
    output logic mem_ready_out,
    output logic mem_ack_out,
    output logic [7:0] pending_out
);
    logic [15:0] lfsr;
    logic take;
    assign take = mem_in.valid && mem_ready_out;
    // stalls come from a local lfsr so the bench need not script every cycle
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lfsr <= 16'hACE1;
            mem_ready_out <= 1'b0;
            mem_ack_out <= 1'b0;
            pending_out <= 8'h00;
        end else begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            mem_ready_out <= !slow_in || lfsr[0];
            pending_out <= pending_out + 8'(take) - 8'(mem_ack_out);
            // only words taken at an earlier edge can complete
            mem_ack_out <= (pending_out - 8'(mem_ack_out) != 8'h00) && !ack_stop_in
                && (!slow_in || lfsr[1]);
        end
    end
endmodule

// ### sim/test_memory_barrier_ordering_unit.sv
`timescale 1ns/1ps
module test_memory_barrier_ordering_unit;
    import mbo_pkg::*;
    logic clock_in, nrst_in, req_valid_in, req_ready_out, mem_ready_in, mem_ack_in;
    logic exec_hold_out, flush_out, ctx_apply_out, predict_ctx_new_out, idle_out;
    logic slow, ack_stop, ctx_seen;
    logic [7:0] pend;
    logic [31:0] seed = 32'h0000_6B4A;
    logic [31:0] r;
    logic [32:0] exp_q[$];
    mbo_req_t req_in;
    mbo_mem_t mem_out;
    int err_total = 0;
    int cmp_count = 0;
    mbo_unit #(.OUT_MAX(8)) DUT (.clock_in(clock_in), .nrst_in(nrst_in), .req_in(req_in),
        .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .mem_out(mem_out),
        .mem_ready_in(mem_ready_in), .mem_ack_in(mem_ack_in), .exec_hold_out(exec_hold_out),
        .flush_out(flush_out), .ctx_apply_out(ctx_apply_out),
        .predict_ctx_new_out(predict_ctx_new_out), .idle_out(idle_out));
    mbo_mem_model far (.clock_in(clock_in), .nrst_in(nrst_in), .mem_in(mem_out),
        .slow_in(slow), .ack_stop_in(ack_stop), .mem_ready_out(mem_ready_in),
        .mem_ack_out(mem_ack_in), .pending_out(pend));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // sampled mid-cycle: what the next edge will hand to memory
    // latched as the pulse rises, so a check on the next negedge cannot race it
    always @(posedge ctx_apply_out) ctx_seen = 1'b1;
    always @(negedge clock_in) begin
        if (mem_out.valid === 1'b1 && mem_ready_in === 1'b1)
            check({mem_out.write, mem_out.addr}, exp_q.size() ? exp_q.pop_front() : '1);
    end
    // words expected lowest address first, one instruction after another
    task issue(input mbo_op_t op, input logic wr, input logic [31:0] base,
            input logic [3:0] n, input logic desc, input logic ctx);
        logic [31:0] a;
        a = desc ? base - {26'h0, n, 2'b00} : base;
        if (op == MBO_OP_ACCESS)
            for (int i = 0; i < n; i++) exp_q.push_back({wr, a + 32'(4 * i)});
        @(posedge clock_in);
        req_in <= '{op, wr, base, n, desc, 1'b0, ctx, rnd()};
        req_valid_in <= 1'b1;
        @(negedge clock_in);
        while (req_ready_out !== 1'b1) @(negedge clock_in);
        @(posedge clock_in);
        req_valid_in <= 1'b0;
    endtask
    task wait_ready;
        @(negedge clock_in);
        while (req_ready_out !== 1'b1) @(negedge clock_in);
    endtask
    // barrier with acknowledgements withheld, then let go
    task barrier(input mbo_op_t op);
        // start drained so withheld acks cannot hit the outstanding cap
        wait_ready();
        while (idle_out !== 1'b1) @(negedge clock_in);
        ack_stop <= 1'b1;
        ctx_seen = 1'b0;
        issue(MBO_OP_ACCESS, 1'b1, 32'h0000_0040, 4'h2, 1'b0, op == MBO_OP_COMPLETE);
        issue(op, 1'b0, 32'h0, 4'h0, 1'b0, 1'b0);
        repeat (4) @(negedge clock_in);
        check(exec_hold_out, op != MBO_OP_ORDER);
        check(req_ready_out, 0);
        check(ctx_seen, 0);
        ack_stop <= 1'b0;
        wait_ready();
        check(pend, 0);
        check(ctx_seen, op == MBO_OP_COMPLETE);
        check(exec_hold_out, 0);
        check(idle_out, 1);
    endtask
    initial begin
        clock_in = 0;
        forever #12.5 clock_in = ~clock_in;
    end
    initial begin
        #(25 * 40000);
        err_total++;
        conclude();
    end
    initial begin
        nrst_in = 0;
        req_valid_in = 0;
        req_in = '0;
        slow = 0;
        ack_stop = 0;
        ctx_seen = 0;
        repeat (10) @(posedge clock_in);
        nrst_in <= 1'b1;
        @(negedge clock_in);
        check(req_ready_out, 1);
        check(idle_out, 1);
        check(exec_hold_out, 0);
        check(mem_out.valid, 0);
        // fast then stalling memory, back-to-back instructions
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            issue(MBO_OP_ACCESS, 1'b1, 32'h0000_1000, 4'h3, 1'b0, 1'b0);
            issue(MBO_OP_ACCESS, 1'b0, 32'h0000_2000, 4'h2, 1'b1, 1'b0);
            issue(MBO_OP_ACCESS, 1'b0, 32'h0000_3000, 4'h0, 1'b0, 1'b0);
            repeat (4) begin
                r = rnd();
                issue(MBO_OP_ACCESS, r[0], {r[31:2], 2'b00}, r[7:4], r[8], 1'b0);
            end
            barrier(MBO_OP_ORDER);
            barrier(MBO_OP_COMPLETE);
        end
        issue(MBO_OP_FLUSH, 1'b0, 32'h0, 4'h0, 1'b0, 1'b0);
        @(negedge clock_in);
        check(exec_hold_out, 1);
        @(negedge clock_in);
        check(flush_out, 1);
        check(exec_hold_out, 0);
        @(negedge clock_in);
        check(predict_ctx_new_out, 1);
        check(flush_out, 0);
        wait_ready();
        // an empty operation is taken and leaves the unit idle
        issue(MBO_OP_NONE, 1'b0, 32'h0, 4'h0, 1'b0, 1'b0);
        @(negedge clock_in);
        check(req_ready_out, 1);
        check(idle_out, 1);
        repeat (20) @(negedge clock_in);
        check(exp_q.size(), 0);
        conclude();
    end
endmodule
